//--- testbench/capture_sink_model.sv
// capture sink model that accepts output beats with random stalls
`timescale 1ns/1ps
module capture_sink_model
(
   // clock
   input wire logic mclk_i,
   // stall request from the bench
   input wire logic hold_i,
   // beat handshake
   output logic sink_ready_o
);
   // ----------------------------------------------------------------
   // ready pattern
   // ----------------------------------------------------------------
   // changes just after rising edges; random gaps keep the buffer busy
   initial sink_ready_o = 1'b0;
   always @(posedge mclk_i)
      sink_ready_o <= !hold_i && ($urandom % 4 != 0);
endmodule : capture_sink_model

//--- testbench/tb_video_output_format_ctrl.sv
// self-checking bench for the output format registers and pixel path
`timescale 1ns/1ps
module tb_video_output_format_ctrl
   import vofc_pkg::*;
;
   logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, in_valid_i, hold;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, luma_o, chroma_o;
   logic [9:0] restore_end_o;
   logic square_pixel_o, burst_mode_o, chroma_line_aligned_o;
   logic output_drive_enable_o, in_ready_o, sink_ready_i, rd_d;
   logic pixel_valid_out_o, active_o, field_o, hsync_o, vsync_o;
   pixel_t in_pix_i;
   pixel_t out_pix;
   pixel_t exp_q[$];
   logic [7:0] rd_q[$];
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   video_output_format_ctrl #(.BUF_DEPTH(2)) uut (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .restore_end_o(restore_end_o),
      .square_pixel_o(square_pixel_o), .burst_mode_o(burst_mode_o),
      .chroma_line_aligned_o(chroma_line_aligned_o),
      .output_drive_enable_o(output_drive_enable_o),
      .in_valid_i(in_valid_i), .in_pix_i(in_pix_i),
      .in_ready_o(in_ready_o), .sink_ready_i(sink_ready_i),
      .pixel_valid_out_o(pixel_valid_out_o), .luma_o(luma_o),
      .chroma_o(chroma_o), .active_o(active_o), .field_o(field_o),
      .hsync_o(hsync_o), .vsync_o(vsync_o));
   capture_sink_model sink (.mclk_i(mclk_i), .hold_i(hold),
      .sink_ready_o(sink_ready_i));

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic bad(input string m);
      fail_count++;
      $display("ERROR %0t %s", $time, m);
   endtask : bad
   task automatic chk_lvl(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
         bad("level mismatch");
   endtask : chk_lvl
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
         bad($sformatf("read %h expected %h", got, exp));
   endtask : chk_reg
   task automatic chk_beat(input pixel_t got);
      n_tests++;
      if (exp_q.size() == 0)
         bad("unexpected beat");
      else if (got !== exp_q.pop_front())
         bad("beat mismatch");
   endtask : chk_beat
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------
   // drivers; every task starts and ends just after a falling edge
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge mclk_i);
      reg_wr_i = 1'b0;
      @(negedge mclk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge mclk_i);
      reg_rd_i = 1'b0;
      @(negedge mclk_i);
   endtask : rd
   task automatic send_pix(input pixel_t p);
      in_valid_i = 1'b1;
      in_pix_i = p;
      while (in_ready_o !== 1'b1)
         @(negedge mclk_i);
      @(negedge mclk_i);
   endtask : send_pix
   function automatic logic keep(input logic [2:0] s, input int k);
      case (s)
         CAP_NONE: keep = 1'b0;
         CAP_FOURTH, CAP_SECOND_ODD: keep = (k % 4 == 0);
         CAP_SECOND, CAP_ODD: keep = (k % 2 == 0);
         CAP_SECOND_EVEN: keep = (k % 4 == 1);
         CAP_EVEN: keep = (k % 2 == 1);
         default: keep = 1'b1;
      endcase
   endfunction : keep

   // eight fields, odd first, two pixels each; burst splits every pixel
   task automatic run_cap(input logic [2:0] s, input logic burst,
      input logic mid, input logic stall);
      pixel_t p, b;
      logic [2:0] cur, fsel;
      cur = s;
      sys_rst_i = 1'b1;
      @(negedge mclk_i);
      sys_rst_i = 1'b0;
      wr(SUBADDR_FORMAT, {1'b0, s, burst, 3'b100});
      chk_lvl(burst_mode_o, burst);
      chk_lvl(output_drive_enable_o, 1'b1);
      hold = stall;
      fork
         for (int k = 0; k < 8; k++)
            for (int j = 0; j < 2; j++)
            begin
               if (mid && k == 2 && j == 1)
               begin
                  in_valid_i = 1'b0;
                  wr(SUBADDR_FORMAT, 8'h04);
                  cur = CAP_NONE;
               end
               if (j == 0)
                  fsel = cur;
               p = pixel_t'(20'($urandom));
               p.field = (k % 2 == 0);
               b = p;
               b.chroma = 8'h00;
               b.luma = p.chroma;
               if (keep(fsel, k) && burst)
                  exp_q.push_back(b);
               b.luma = p.luma;
               if (keep(fsel, k))
                  exp_q.push_back(burst ? b : p);
               send_pix(p);
            end
         if (stall)
         begin
            repeat (12) @(negedge mclk_i);
            chk_lvl(in_ready_o, 1'b0);
            hold = 1'b0;
         end
      join
      in_valid_i = 1'b0;
      repeat (60) @(negedge mclk_i);
      chk_lvl(exp_q.size() == 0, 1'b1);
      $display("test capture %h burst %b mid %b done", s, burst, mid);
   endtask : run_cap

   // ----------------------------------------------------------------
   // monitor, clock, timeout, main sequence
   // ----------------------------------------------------------------
   assign out_pix = {luma_o, chroma_o, active_o, field_o, hsync_o, vsync_o};
   always @(posedge mclk_i)
      rd_d <= reg_rd_i;
   always @(negedge mclk_i)
   begin
      if (rd_d === 1'b1)
         chk_reg(reg_rdata_o, rd_q.pop_front());
      if (pixel_valid_out_o === 1'b1 && sink_ready_i === 1'b1)
         chk_beat(out_pix);
   end
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad("timeout");
         final_report();
      end
   end
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial
   begin
      logic [7:0] lo;
      void'($urandom(32'h68b787b2));
      {sys_rst_i, reg_wr_i, reg_rd_i, in_valid_i, hold} = 5'h10;
      {reg_addr_i, reg_wdata_i, in_pix_i} = '0;
      repeat (2) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      rd(SUBADDR_RESTORE_LOW, 8'h52);
      rd(SUBADDR_RESTORE_HIGH, 8'h00);
      rd(SUBADDR_FORMAT, 8'h00);
      chk_lvl(restore_end_o === 10'h052, 1'b1);
      lo = 8'($urandom);
      wr(SUBADDR_RESTORE_LOW, lo);
      wr(SUBADDR_RESTORE_HIGH, 8'hff);
      rd(SUBADDR_RESTORE_LOW, lo);
      rd(SUBADDR_RESTORE_HIGH, 8'h03);
      chk_lvl(restore_end_o === {2'b11, lo}, 1'b1);
      for (int b = 0; b < 8; b++)
      begin
         wr(SUBADDR_FORMAT, 8'h01 << b);
         rd(SUBADDR_FORMAT, (8'h01 << b) & 8'hfe);
         chk_lvl(square_pixel_o, b == 7);
         chk_lvl(burst_mode_o, b == 3);
         chk_lvl(output_drive_enable_o, b == 2);
         chk_lvl(chroma_line_aligned_o, b == 1);
      end
      wr(8'h17, 8'hff);
      rd(8'h17, 8'h00);
      $display("test registers done");
      for (int s = 0; s < 8; s++)
         run_cap(3'(s), 1'b0, 1'b0, s == 7);
      run_cap(CAP_ALL, 1'b1, 1'b0, 1'b0);
      run_cap(CAP_ALL, 1'b0, 1'b1, 1'b0);
      final_report();
   end
endmodule : tb_video_output_format_ctrl

//--- verilog/video_output_format_ctrl.sv
// restore end-time and output format registers with the output pixel path
`timescale 1ns/1ps
module video_output_format_ctrl
   import vofc_pkg::*;
#(
   parameter int BUF_DEPTH = 2
)
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // sub-address register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // settings towards the decoder core
   output logic [9:0] restore_end_o,
   output logic square_pixel_o,
   output logic burst_mode_o,
   output logic chroma_line_aligned_o,
   output logic output_drive_enable_o,
   // pixels from the decoder core
   input wire logic in_valid_i,
   input wire pixel_t in_pix_i,
   output logic in_ready_o,
   // pixels to the capture sink
   input wire logic sink_ready_i,
   output logic pixel_valid_out_o,
   output logic [7:0] luma_o,
   output logic [7:0] chroma_o,
   output logic active_o,
   output logic field_o,
   output logic hsync_o,
   output logic vsync_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CNT_W = $clog2(BUF_DEPTH + 1);

   generate
      if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("BUF_DEPTH must be a power of two, at least 2");
      end
   endgenerate

   // ----------------------------------------------------------------
   // capture decision per field
   // ----------------------------------------------------------------
   function automatic logic capture_field(
      input logic [2:0] sel,
      input logic odd,
      input logic [1:0] all_cnt,
      input logic odd_cnt,
      input logic even_cnt
   );
      logic take;
      take = 1'b0;
      unique case (sel)
         CAP_NONE: take = 1'b0;
         CAP_FOURTH: take = (all_cnt == 2'h0);
         CAP_SECOND: take = !all_cnt[0];
         CAP_SECOND_ODD: take = odd && !odd_cnt;
         CAP_SECOND_EVEN: take = !odd && !even_cnt;
         CAP_ODD: take = odd;
         CAP_EVEN: take = !odd;
         CAP_ALL: take = 1'b1;
      endcase
      return take;
   endfunction : capture_field

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic [2:0] field_capture_select;
   wire wr_low = reg_wr_i && (reg_addr_i == SUBADDR_RESTORE_LOW);
   wire wr_high = reg_wr_i && (reg_addr_i == SUBADDR_RESTORE_HIGH);
   wire wr_fmt = reg_wr_i && (reg_addr_i == SUBADDR_FORMAT);
   // unused low bit is simply not stored
   wire [7:0] fmt_rd = {square_pixel_o, field_capture_select,
                        burst_mode_o, output_drive_enable_o,
                        chroma_line_aligned_o, 1'b0};
   wire [7:0] rd_mux =
      (reg_addr_i == SUBADDR_RESTORE_LOW) ? restore_end_o[7:0] :
      (reg_addr_i == SUBADDR_RESTORE_HIGH) ?
         {6'h00, restore_end_o[9:8]} :
      (reg_addr_i == SUBADDR_FORMAT) ? fmt_rd : 8'h00;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         restore_end_o <= RESTORE_END_RST;
         square_pixel_o <= 1'b0;
         field_capture_select <= FIELD_SEL_RST;
         burst_mode_o <= 1'b0;
         output_drive_enable_o <= 1'b0;
         chroma_line_aligned_o <= 1'b0;
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         if (wr_low)
            restore_end_o[RESTORE_LOW_W-1:0] <= reg_wdata_i;
         if (wr_high)
            restore_end_o[9:RESTORE_LOW_W] <= reg_wdata_i[1:0];
         if (wr_fmt)
         begin
            square_pixel_o <= reg_wdata_i[FMT_SQUARE_BIT];
            field_capture_select <= reg_wdata_i[FMT_SEL_LSB +: 3];
            burst_mode_o <= reg_wdata_i[FMT_BURST_BIT];
            output_drive_enable_o <= reg_wdata_i[FMT_OEN_BIT];
            chroma_line_aligned_o <= reg_wdata_i[FMT_SITE_BIT];
         end
         if (reg_rd_i)
            reg_rdata_o <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // field boundary and capture gating
   // ----------------------------------------------------------------
   // the select is sampled only here, so a field is kept or dropped whole
   logic last_field;
   logic field_on;
   logic [1:0] all_cnt;
   logic odd_cnt;
   logic even_cnt;
   wire take_in = in_valid_i && in_ready_o;
   wire boundary = take_in && (in_pix_i.field != last_field);
   wire next_on = capture_field(field_capture_select, in_pix_i.field,
                                all_cnt, odd_cnt, even_cnt);
   wire keep = boundary ? next_on : field_on;

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         last_field <= 1'b0;
         field_on <= 1'b0;
         all_cnt <= 2'h0;
         odd_cnt <= 1'b0;
         even_cnt <= 1'b0;
      end
      else if (boundary)
      begin
         last_field <= in_pix_i.field;
         field_on <= next_on;
         all_cnt <= all_cnt + 2'h1;
         if (in_pix_i.field)
            odd_cnt <= !odd_cnt;
         else
            even_cnt <= !even_cnt;
      end
   end

   // ----------------------------------------------------------------
   // BUF_DEPTH-entry buffer (two by default)
   // ----------------------------------------------------------------
   pixel_t mem [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   beat_t beat;
   pixel_t head;
   assign head = mem[rd_ptr];
   wire push = take_in && keep;
   wire have = (count != '0);
   wire adv = !pixel_valid_out_o || sink_ready_i;
   // burst mode sends chroma then luma of one pixel on the luma lanes
   wire split = burst_mode_o && (beat == BEAT_CHROMA);
   wire pop = adv && have && !split;
   wire [CNT_W-1:0] next_count = count + CNT_W'(push) - CNT_W'(pop);

   always_ff @(posedge mclk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_pix_i;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + PTR_W'(1);
         if (pop)
            rd_ptr <= rd_ptr + PTR_W'(1);
         count <= next_count;
         // ready stays low while full, so a stalled sink loses nothing
         in_ready_o <= (next_count != CNT_W'(BUF_DEPTH));
      end
   end

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pixel_valid_out_o <= 1'b0;
         luma_o <= 8'h00;
         chroma_o <= 8'h00;
         active_o <= 1'b0;
         field_o <= 1'b0;
         hsync_o <= 1'b0;
         vsync_o <= 1'b0;
         beat <= BEAT_CHROMA;
      end
      else if (adv)
      begin
         pixel_valid_out_o <= have;
         if (have)
         begin
            luma_o <= split ? head.chroma : head.luma;
            chroma_o <= burst_mode_o ? 8'h00 : head.chroma;
            active_o <= head.active;
            field_o <= head.field;
            hsync_o <= head.hsync;
            vsync_o <= head.vsync;
            beat <= split ? BEAT_LUMA : BEAT_CHROMA;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_fmt_write;
      wr_fmt;
   endsequence

   sequence s_field_start;
      boundary;
   endsequence

   property p_low_write;
      wr_low |=> restore_end_o[7:0] == $past(reg_wdata_i);
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("restore low byte not stored");

   property p_high_read;
      reg_rd_i && !reg_wr_i && reg_addr_i == SUBADDR_RESTORE_HIGH
         |=> reg_rdata_o == {6'h00, restore_end_o[9:8]};
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("restore high readback wrong");

   property p_square;
      s_fmt_write |=> square_pixel_o == $past(reg_wdata_i[FMT_SQUARE_BIT]);
   endproperty
   a_square: assert property (p_square)
      else $error("square pixel select not taken");

   property p_cap_none;
      s_field_start and (field_capture_select == CAP_NONE)
         |=> !field_on ##1 (count == '0 || $past(count) != '0);
   endproperty
   a_cap_none: assert property (p_cap_none)
      else $error("field captured while capture disabled");

   property p_cap_all;
      s_field_start and (field_capture_select == CAP_ALL) |=> field_on;
   endproperty
   a_cap_all: assert property (p_cap_all)
      else $error("field dropped while all selected");

   property p_burst;
      adv && have && burst_mode_o |=> chroma_o == 8'h00;
   endproperty
   a_burst: assert property (p_burst)
      else $error("chroma lanes busy in burst mode");

   property p_oen;
      s_fmt_write
         |=> output_drive_enable_o == $past(reg_wdata_i[FMT_OEN_BIT]);
   endproperty
   a_oen: assert property (p_oen)
      else $error("output enable not taken");

   property p_site;
      s_fmt_write
         |=> chroma_line_aligned_o == $past(reg_wdata_i[FMT_SITE_BIT]);
   endproperty
   a_site: assert property (p_site)
      else $error("siting bit not taken");

   property p_unused;
      reg_rd_i && reg_addr_i == SUBADDR_FORMAT
         |=> reg_rdata_o[FMT_UNUSED_BIT] == 1'b0;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused format bit read as one");

   property p_hold_sel;
      !boundary |=> $stable(field_on);
   endproperty
   a_hold_sel: assert property (p_hold_sel)
      else $error("capture changed inside a field");

endmodule : video_output_format_ctrl

//--- verilog/vofc_pkg.sv
// constants, field layout and pixel type of the video output format block
package vofc_pkg;

   // ----------------------------------------------------------------
   // sub-addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] SUBADDR_RESTORE_LOW = 8'h14;
   localparam logic [7:0] SUBADDR_RESTORE_HIGH = 8'h15;
   localparam logic [7:0] SUBADDR_FORMAT = 8'h16;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [9:0] RESTORE_END_RST = 10'h052;
   localparam logic [2:0] FIELD_SEL_RST = 3'h0;

   // ----------------------------------------------------------------
   // output format field positions
   // ----------------------------------------------------------------
   localparam int FMT_SQUARE_BIT = 7;
   localparam int FMT_SEL_LSB = 4;
   localparam int FMT_BURST_BIT = 3;
   localparam int FMT_OEN_BIT = 2;
   localparam int FMT_SITE_BIT = 1;
   localparam int FMT_UNUSED_BIT = 0;
   localparam int RESTORE_LOW_W = 8;

   // ----------------------------------------------------------------
   // field capture codes
   // ----------------------------------------------------------------
   localparam logic [2:0] CAP_NONE = 3'h0;
   localparam logic [2:0] CAP_FOURTH = 3'h1;
   localparam logic [2:0] CAP_SECOND = 3'h2;
   localparam logic [2:0] CAP_SECOND_ODD = 3'h3;
   localparam logic [2:0] CAP_SECOND_EVEN = 3'h4;
   localparam logic [2:0] CAP_ODD = 3'h5;
   localparam logic [2:0] CAP_EVEN = 3'h6;
   localparam logic [2:0] CAP_ALL = 3'h7;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] luma;
      logic [7:0] chroma;
      logic active;
      logic field;
      logic hsync;
      logic vsync;
   } pixel_t;

   typedef enum logic {BEAT_CHROMA, BEAT_LUMA} beat_t;

endpackage : vofc_pkg
